// >>> inc/sipo_defines.vh
`ifndef SIPO_DEFINES_VH
`define SIPO_DEFINES_VH
// shift and storage width
`define SIPO_WIDTH 8
// reset value of the shift stages
`define SIPO_SHIFT_RST 8'h00
// synchroniser depth for pin inputs
`define SIPO_SYNC_DEPTH 3
`endif

// >>> rtl/sipo_latch.v
`include "sipo_defines.vh"
`timescale 1ns/1ns
`default_nettype none
// Function
// - eight-bit shift register and storage register, each on its own clock input.
// - shift register advances once per shift clock rising edge only.
// - serial data enters stage 0; each stage moves up one.
// - cascade output shows stage 7, the old stage 6 after a shift.
// - storage clock rising edge copies all eight stages into storage.
// - simultaneous edges load storage with the pre-shift content.
// - output enable low drives storage bits on the parallel outputs.
// - output enable high releases parallel outputs; cascade output still driven.
// - output enable never changes shift or storage content.
// - clear low forces stages and cascade output low; storage holds.
// - storage edge during clear loads all zeros into storage.
module sipo_latch
#(
  parameter WIDTH = `SIPO_WIDTH
)
(
  input wire clock,
  input wire rst_n,
  input wire serial_data_in,
  input wire shift_clock_in,
  input wire storage_clock_in,
  input wire shift_clear_n,
  input wire output_enable_n,
  output wire [WIDTH-1:0] parallel_out,
  output wire [WIDTH-1:0] parallel_out_oe,
  output wire cascade_out
);
  // ****************************************
  // pin sampling
  // ****************************************
  wire data_lvl;
  wire shift_rise;
  wire store_rise;
  wire clear_lvl_n;
  wire oe_lvl_n;

  sipo_pin_sync u_sync_data
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(serial_data_in),
    .level_out(data_lvl),
    .rise_out()
  );

  sipo_pin_sync u_sync_shift
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(shift_clock_in),
    .level_out(),
    .rise_out(shift_rise)
  );

  sipo_pin_sync u_sync_store
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(storage_clock_in),
    .level_out(),
    .rise_out(store_rise)
  );

  // clear is async on the real part; here it is sampled, and it also
  // gates the stages combinationally so the cascade drops at once
  sipo_pin_sync u_sync_clear
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(shift_clear_n),
    .level_out(clear_lvl_n),
    .rise_out()
  );

  sipo_pin_sync u_sync_oe
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(output_enable_n),
    .level_out(oe_lvl_n),
    .rise_out()
  );

  // ****************************************
  // shift register
  // ****************************************
  reg [WIDTH-1:0] shift_r;
  reg [WIDTH-1:0] shift_nxt;
  wire [WIDTH-1:0] stages;

  always @*
  begin
    shift_nxt = shift_r;
    if (!clear_lvl_n)
      shift_nxt = `SIPO_SHIFT_RST;
    else if (shift_rise)
      shift_nxt = {shift_r[WIDTH-2:0], data_lvl};
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= `SIPO_SHIFT_RST;
    else
      shift_r <= shift_nxt;
  end

  // cleared stages read low while clear holds
  assign stages = clear_lvl_n ? shift_r : `SIPO_SHIFT_RST;
  assign cascade_out = stages[WIDTH-1];

  // ****************************************
  // storage register
  // ****************************************
  wire [WIDTH-1:0] store_q;

  // loads from the current, pre-shift stages, so storage lags by one
  sipo_stage_reg #(.WIDTH(WIDTH)) u_store
  (
    .clock(clock),
    .load(store_rise),
    .data_in(stages),
    .data_out(store_q)
  );

  // ****************************************
  // three-state outputs
  // ****************************************
  // enable only gates the drivers, never the registers
  assign parallel_out = store_q;
  assign parallel_out_oe = {WIDTH{~oe_lvl_n}};
endmodule
`default_nettype wire

// >>> rtl/sipo_pin_sync.v
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// three-stage pin synchroniser with agreement check
// ****************************************
module sipo_pin_sync
(
  input wire clock,
  input wire rst_n,
  input wire pin_in,
  output wire level_out,
  output wire rise_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg lvl_r;
  reg lvl_nxt;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  always @*
  begin
    lvl_nxt = lvl_r;
    if (s2_r == s3_r)
      lvl_nxt = s3_r;
  end

  assign level_out = lvl_nxt;
  assign rise_out = lvl_nxt & ~lvl_r;
endmodule
`default_nettype wire

// >>> rtl/sipo_stage_reg.v
`include "sipo_defines.vh"
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// storage register, no reset
// ****************************************
module sipo_stage_reg
#(
  parameter WIDTH = `SIPO_WIDTH
)
(
  input wire clock,
  input wire load,
  input wire [WIDTH-1:0] data_in,
  output wire [WIDTH-1:0] data_out
);
  reg [WIDTH-1:0] store_r;

  // no reset: content is undefined until the first load
  always @(posedge clock)
  begin
    if (load)
      store_r <= data_in;
  end

  assign data_out = store_r;
endmodule
`default_nettype wire

// >>> tb/sipo_host.sv
`timescale 1ns/1ns
`default_nettype none
// **
// host model, 320 ns link clock, stopped between frames
// **
module sipo_host
(
  input wire logic clock,
  output logic serial_data_in = 1'h0,
  output logic shift_clock_in = 1'h0,
  output logic storage_clock_in = 1'h0
);
  // eight shifts then a store; released data is inverted, not held
  task automatic send(input logic [7:0] d, input logic both);
    for (int i = 7; i >= -1; i--)
    begin
      serial_data_in = i < 0 ? ~d[0] : d[i];
      repeat (4) @(negedge clock);
      shift_clock_in = i >= 0;
      storage_clock_in = i < 0 || both && i == 0;
      repeat (4) @(negedge clock);
      {shift_clock_in, storage_clock_in} = 2'h0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/sipo_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// **
// port checker
// **
module sipo_monitor
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shift_clock_in,
  input wire logic storage_clock_in,
  input wire logic shift_clear_n,
  input wire logic output_enable_n,
  input wire logic [7:0] parallel_out,
  input wire logic [7:0] parallel_out_oe,
  input wire logic cascade_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // five quiet cycles, so any earlier shift has landed
  sequence idle; (!shift_clock_in && shift_clear_n) [*5]; endsequence
  chk_oe_off: assert property (output_enable_n [*5] |-> parallel_out_oe == '0)
    else $error("oe");
  chk_oe_on: assert property (!output_enable_n [*5] |-> &parallel_out_oe)
    else $error("oe");
  chk_clr_casc: assert property (!shift_clear_n [*5] |-> !cascade_out)
    else $error("clr");
  chk_clr_store: assert property (!shift_clear_n [*3] ##1
    (!shift_clear_n && $rose(storage_clock_in)) |-> ##[3:6] parallel_out == '0) else $error("clr");
  chk_casc_hold: assert property (idle |-> cascade_out === $past(cascade_out))
    else $error("casc");
  chk_store_hold: assert property (!storage_clock_in [*7] |->
    parallel_out === $past(parallel_out)) else $error("store");
  chk_both_edge: assert property ($rose(storage_clock_in) && $rose(shift_clock_in) |->
    ##6 parallel_out[7] == $past(cascade_out, 6)) else $error("both");
  chk_store_casc: assert property (!shift_clock_in [*4] ##0 !storage_clock_in ##1
    (storage_clock_in && !shift_clock_in) [*3] ##1 idle |-> parallel_out[7] == cascade_out)
    else $error("load");
endmodule
`default_nettype wire

// >>> tb/tb_sipo_latch.sv
`timescale 1ns/1ns
`default_nettype none
// **
// bench: random bytes through the host, stored results compared
// **
module tb_sipo_latch;
  logic clock = 1'h0, rst_n = 1'h0, shift_clear_n = 1'h1, output_enable_n = 1'h0;
  logic serial_data_in, shift_clock_in, storage_clock_in, cascade_out;
  logic [7:0] parallel_out, a;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'hD359742A;
  int n_fail = 0, comparisons = 0;
  sipo_latch i_sipo_latch (.clock, .rst_n, .serial_data_in, .shift_clock_in, .storage_clock_in,
    .shift_clear_n, .output_enable_n, .parallel_out, .parallel_out_oe(), .cascade_out);
  sipo_host i_sipo_host (.clock, .serial_data_in, .shift_clock_in, .storage_clock_in);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    $display("fails %0d checks %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #20 clock = ~clock;
  initial
  begin
    #60000;
    n_fail++;
    finish_test();
  end
  always @(negedge storage_clock_in iff rst_n)
  begin
    repeat (3) @(negedge clock);
    comparisons++;
    if ({cascade_out, parallel_out} !== exp_q.pop_front())
    begin
      n_fail++;
      $display("BAD %0t stored value", $time);
    end
  end
  initial
  begin
    repeat (5) @(negedge clock);
    rst_n = 1'h1;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 6; k++)
    begin
      repeat (4) @(negedge clock);
      seed = lfsr(seed);
      output_enable_n = k[0];
      shift_clear_n = k != 5;
      if (k == 4)
        exp_q.push_back({seed[7], a[0], seed[7:1]});
      exp_q.push_back(k == 5 ? 9'h000 : {seed[7], seed[7:0]});
      i_sipo_host.send(seed[7:0], k == 4);
      a = seed[7:0];
    end
    repeat (4) @(negedge clock);
    finish_test();
  end
endmodule
bind sipo_latch sipo_monitor i_sipo_monitor (.clock, .rst_n, .shift_clock_in,
  .storage_clock_in, .shift_clear_n, .output_enable_n, .parallel_out, .parallel_out_oe,
  .cascade_out);
`default_nettype wire
